// >>> src/sfi_pkg.sv
package sfi_pkg;
  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_CHECK_EN = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_PERIOD = 8'h0c;
  localparam logic [7:0] ADDR_FLAGS = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
  localparam logic [7:0] ADDR_OUT_STATE = 8'h1c;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CFG_LOCK_BIT = 0;
  localparam int CFG_DIAG_OFF_BIT = 1;
  localparam int CFG_LATCH_BIT = 2;
  localparam int CFG_OV_OFF_BIT = 3;
  localparam int CFG_BAND_BIT = 7;
  localparam int CHK_MEM_BIT = 0;
  localparam int CHK_ROM_BIT = 1;
  localparam int CHK_FSM_BIT = 2;
  localparam int CHK_ADD_BIT = 3;
  localparam int CTRL_PWM_BIT = 0;
  localparam int NFAULT = 9;
  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] CFG_RST = 16'h0000;
  localparam logic [3:0] CHECK_RST = 4'h0;
  localparam logic [0:0] CTRL_RST = 1'h0;
  localparam logic [NFAULT-1:0] MASK_RST = 9'h000;
  // 40000 cycles at 40 MHz gives 1 kHz
  localparam logic [15:0] PERIOD_RST = 16'h9c40;
  // ---------------------------------------------------------------
  // Output levels and duty codes (percent)
  // ---------------------------------------------------------------
  localparam logic [15:0] LVL_HIGH_BAND = 16'hffff;
  localparam logic [15:0] LVL_LOW_BAND = 16'h0000;
  localparam logic [15:0] LVL_GROUND = 16'h0000;
  localparam logic [6:0] DUTY_SELFTEST = 7'h5f;
  localparam logic [6:0] DUTY_ADDER = 7'h55;
  localparam logic [6:0] DUTY_OVERVOLT = 7'h4b;
  localparam logic [6:0] DUTY_UNDERVOLT = 7'h64;
  localparam logic [23:0] PCT_FULL = 24'h000064;
  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic supply_break;
    logic ground_break;
    logic undervolt;
    logic overtemp;
    logic overvolt;
    logic mem_fail;
    logic rom_fail;
    logic fsm_fail;
    logic adder_ovf;
  } sfi_fault_t;

  typedef enum logic [1:0] {
    OST_NORMAL = 2'h0,
    OST_ERROR = 2'h1,
    OST_HIZ = 2'h3,
    OST_GROUND = 2'h2
  } sfi_ost_t;
endpackage

// >>> src/sfi_pwm.sv
`timescale 1ns/1ps
`default_nettype none
module sfi_pwm import sfi_pkg::*; (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Control
  input wire logic enable,
  input wire logic fault,
  input wire logic [15:0] period,
  input wire logic [6:0] duty_pct,
  // Pin
  output logic pwm_o
);
  logic [16:0] cnt_reg;
  logic [16:0] len_reg;
  logic [6:0] duty_reg;
  logic [16:0] len_next;
  logic wrap;

  // Doubling the period halves the frequency while a fault lasts
  assign len_next = fault ? {period, 1'b0} : {1'b0, period}; // see RQ7
  assign wrap = (cnt_reg + 17'h00001 >= len_reg);

  // Period and duty are taken only at a period start to avoid runt pulses
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= 17'h00000;
      len_reg <= {1'b0, PERIOD_RST};
      duty_reg <= 7'h00;
    end else if (ce) begin
      if (!enable || wrap) begin
        cnt_reg <= 17'h00000;
        len_reg <= len_next;
        duty_reg <= duty_pct;
      end else begin
        cnt_reg <= cnt_reg + 17'h00001;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwm_o <= 1'b0;
    end else if (ce) begin
      pwm_o <= enable && ({7'h00, cnt_reg} * PCT_FULL < {17'h00000, duty_reg} * {7'h00, len_reg}); // see RQ8
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  pwm_half_freq_a: assert property (@(posedge aclk) disable iff (!aresetn) // see RQ7
    ce && (wrap || !enable) && fault |=> len_reg == {$past(period), 1'b0})
    else $error("fault period is not twice the configured period");
endmodule
`default_nettype wire

// >>> src/sfi_top.sv
// Summary of operation
// RQ1 - Wire-break, undervoltage, thermal checks always active; the thermal check here acts only in pulse-width mode
// RQ2 - Overvoltage, memory, ROM, FSM, adder checks optional
// RQ3 - Enabled diagnosis fault forces error band immediately
// RQ4 - Setup word bit 7 picks error band
// RQ5 - Over-temperature puts output into tristate
// RQ6 - Supply wire break drives output to ground
// RQ7 - Pulse-width failure halves output frequency
// RQ8 - Duty codes 95, 85, 75, 100 percent
// RQ9 - Band honoured only when locked, else high
// RQ10 - Diagnosis bit 1 stops errors forcing output
// RQ11 - Latch bit holds flags until reset; here clearing the latch bit also releases them
// RQ12 - Code priority: self-test, adder, overvoltage, undervoltage
//
// Design decisions made here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module sfi_top import sfi_pkg::*; (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Detectors and signal path
  input wire sfi_fault_t faults_i,
  input wire logic [15:0] signal_level_i,
  input wire logic [6:0] duty_pct_i,
  // Output pin and interrupt
  output logic [15:0] out_level,
  output logic pwm_o,
  output logic out_oe_n,
  output logic irq
);
  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [15:0] customer_configuration_word_reg;
  logic [3:0] check_en_reg;
  logic [0:0] ctrl_reg;
  logic [15:0] period_reg;
  sfi_fault_t flags_reg, flags_next, live;
  logic [NFAULT-1:0] irq_stat_reg, irq_stat_next, irq_mask_reg;
  sfi_ost_t ost_reg, ost_next;
  logic [15:0] out_level_next;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic wr_go, rd_go, irq_clr;
  logic [31:0] rd_mux;
  logic rd_ok, wr_ok;
  logic pwm_mode, diag_fault, band_low, pwm_fault;
  logic [6:0] duty_sel;

  assign pwm_mode = ctrl_reg[CTRL_PWM_BIT];

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  logic [31:0] cfg_wr, chk_wr, ctrl_wr, period_wr, mask_wr;
  assign cfg_wr = merge({16'h0000, customer_configuration_word_reg}, w_data_reg, w_strb_reg);
  assign chk_wr = merge({28'h0000000, check_en_reg}, w_data_reg, w_strb_reg);
  assign ctrl_wr = merge({31'h00000000, ctrl_reg}, w_data_reg, w_strb_reg);
  assign period_wr = merge({16'h0000, period_reg}, w_data_reg, w_strb_reg);
  assign mask_wr = merge({23'h000000, irq_mask_reg}, w_data_reg, w_strb_reg);

  // ---------------------------------------------------------------
  // AXI4-Lite slave: one write and one read in flight
  // ---------------------------------------------------------------
  assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign rd_go = s_axi_arvalid && s_axi_arready;
  assign wr_ok = (aw_addr_reg[7:5] == 3'h0) && (aw_addr_reg[1:0] == 2'h0);
  assign rd_ok = (s_axi_araddr[7:5] == 3'h0) && (s_axi_araddr[1:0] == 2'h0);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_comb begin
    rd_mux = 32'h00000000;
    if (s_axi_araddr == ADDR_CFG) begin
      rd_mux[15:0] = customer_configuration_word_reg;
    end else if (s_axi_araddr == ADDR_CHECK_EN) begin
      rd_mux[3:0] = check_en_reg;
    end else if (s_axi_araddr == ADDR_CTRL) begin
      rd_mux[0:0] = ctrl_reg;
    end else if (s_axi_araddr == ADDR_PERIOD) begin
      rd_mux[15:0] = period_reg;
    end else if (s_axi_araddr == ADDR_FLAGS) begin
      rd_mux[NFAULT-1:0] = flags_reg;
    end else if (s_axi_araddr == ADDR_IRQ_STAT) begin
      rd_mux[NFAULT-1:0] = irq_stat_reg;
    end else if (s_axi_araddr == ADDR_IRQ_MASK) begin
      rd_mux[NFAULT-1:0] = irq_mask_reg;
    end else if (s_axi_araddr == ADDR_OUT_STATE) begin
      rd_mux[1:0] = ost_reg;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else if (ce) begin
      if (rd_go) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      customer_configuration_word_reg <= CFG_RST;
      check_en_reg <= CHECK_RST;
      ctrl_reg <= CTRL_RST;
      period_reg <= PERIOD_RST;
      irq_mask_reg <= MASK_RST;
    end else if (ce && wr_go) begin
      if (aw_addr_reg == ADDR_CFG) begin
        customer_configuration_word_reg <= cfg_wr[15:0];
      end else if (aw_addr_reg == ADDR_CHECK_EN) begin
        check_en_reg <= chk_wr[3:0];
      end else if (aw_addr_reg == ADDR_CTRL) begin
        ctrl_reg <= ctrl_wr[0:0];
      end else if (aw_addr_reg == ADDR_PERIOD) begin
        period_reg <= period_wr[15:0];
      end else if (aw_addr_reg == ADDR_IRQ_MASK) begin
        irq_mask_reg <= mask_wr[NFAULT-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Diagnosis flags
  // ---------------------------------------------------------------
  always_comb begin
    live = faults_i; // see RQ1
    live.overtemp = faults_i.overtemp && pwm_mode; // see RQ1
    live.overvolt = faults_i.overvolt && !customer_configuration_word_reg[CFG_OV_OFF_BIT]; // see RQ2
    live.mem_fail = faults_i.mem_fail && check_en_reg[CHK_MEM_BIT]; // see RQ2
    live.rom_fail = faults_i.rom_fail && check_en_reg[CHK_ROM_BIT]; // see RQ2
    live.fsm_fail = faults_i.fsm_fail && check_en_reg[CHK_FSM_BIT]; // see RQ2
    live.adder_ovf = faults_i.adder_ovf && check_en_reg[CHK_ADD_BIT]; // see RQ2
    // A latched flag is released by reset or by clearing the latch bit
    flags_next = customer_configuration_word_reg[CFG_LATCH_BIT] ? (flags_reg | live) : live; // see RQ11
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_reg <= '0;
    end else if (ce) begin
      flags_reg <= flags_next;
    end
  end

  // ---------------------------------------------------------------
  // Output decision
  // ---------------------------------------------------------------
  assign diag_fault = flags_next.undervolt | flags_next.overvolt | flags_next.mem_fail |
                      flags_next.rom_fail | flags_next.fsm_fail | flags_next.adder_ovf;
  // An unlocked part always reports on the high band
  assign band_low = customer_configuration_word_reg[CFG_LOCK_BIT] &&
                    customer_configuration_word_reg[CFG_BAND_BIT]; // see RQ4, RQ9
  assign pwm_fault = pwm_mode && diag_fault && !customer_configuration_word_reg[CFG_DIAG_OFF_BIT]; // see RQ10

  always_comb begin
    if (flags_next.supply_break) begin
      ost_next = OST_GROUND; // see RQ6
    end else if (flags_next.overtemp) begin
      ost_next = OST_HIZ; // see RQ5
    end else if (flags_next.ground_break) begin
      ost_next = OST_ERROR;
    end else if (diag_fault && !customer_configuration_word_reg[CFG_DIAG_OFF_BIT]) begin
      ost_next = OST_ERROR; // see RQ3, RQ10
    end else begin
      ost_next = OST_NORMAL;
    end
  end

  always_comb begin
    case (ost_next)
      OST_GROUND: out_level_next = LVL_GROUND;
      OST_HIZ: out_level_next = LVL_GROUND;
      // A lost ground lifts the pin to supply whatever the band
      OST_ERROR: out_level_next = (band_low && !flags_next.ground_break) ? LVL_LOW_BAND : LVL_HIGH_BAND; // see RQ4
      default: out_level_next = signal_level_i;
    endcase
  end

  always_comb begin
    if (flags_next.mem_fail || flags_next.fsm_fail || flags_next.rom_fail) begin
      duty_sel = DUTY_SELFTEST; // see RQ12, RQ8
    end else if (flags_next.adder_ovf) begin
      duty_sel = DUTY_ADDER; // see RQ12, RQ8
    end else if (flags_next.overvolt) begin
      duty_sel = DUTY_OVERVOLT; // see RQ12, RQ8
    end else if (flags_next.undervolt) begin
      duty_sel = DUTY_UNDERVOLT; // see RQ12, RQ8
    end else begin
      duty_sel = duty_pct_i;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ost_reg <= OST_NORMAL;
      out_level <= LVL_GROUND;
      out_oe_n <= 1'b1;
    end else if (ce) begin
      ost_reg <= ost_next;
      out_level <= out_level_next;
      out_oe_n <= (ost_next == OST_HIZ); // see RQ5
    end
  end

  sfi_pwm u_pwm (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .enable(pwm_mode && (ost_next == OST_NORMAL || (ost_next == OST_ERROR && pwm_fault))),
    .fault(pwm_fault), // see RQ7
    .period(period_reg),
    .duty_pct(pwm_fault ? duty_sel : duty_pct_i),
    .pwm_o(pwm_o)
  );

  // ---------------------------------------------------------------
  // Interrupts: sticky on a new flag, cleared by reading
  // ---------------------------------------------------------------
  assign irq_clr = rd_go && (s_axi_araddr == ADDR_IRQ_STAT);
  // A flag rising in the clearing cycle survives the clear
  assign irq_stat_next = (irq_stat_reg & {NFAULT{!irq_clr}}) | (flags_next & ~flags_reg);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_reg <= '0;
      irq <= 1'b0;
    end else if (ce) begin
      irq_stat_reg <= irq_stat_next;
      irq <= |(irq_stat_next & irq_mask_reg);
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  supply_ground_a: assert property (@(posedge aclk) disable iff (!aresetn) // see RQ6
    ce && faults_i.supply_break |=> ost_reg == OST_GROUND && out_level == LVL_GROUND && !out_oe_n)
    else $error("supply break did not ground the output");
  overtemp_hiz_a: assert property (@(posedge aclk) disable iff (!aresetn) // see RQ5
    ce && flags_next.overtemp && !flags_next.supply_break |=> out_oe_n && !pwm_o)
    else $error("over-temperature did not release the pin");
  error_band_a: assert property (@(posedge aclk) disable iff (!aresetn) // see RQ3
    ce && diag_fault && !customer_configuration_word_reg[CFG_DIAG_OFF_BIT] && !flags_next.supply_break &&
    !flags_next.overtemp |=> ost_reg == OST_ERROR)
    else $error("fault did not reach the error band in one cycle");
  band_select_a: assert property (@(posedge aclk) disable iff (!aresetn) // see RQ4, RQ9
    ce && ost_next == OST_ERROR && !flags_next.ground_break |=>
    out_level == (($past(customer_configuration_word_reg) & 16'h0081) == 16'h0081 ? LVL_LOW_BAND : LVL_HIGH_BAND))
    else $error("wrong error band");
  diag_off_a: assert property (@(posedge aclk) disable iff (!aresetn) // see RQ10
    ce && customer_configuration_word_reg[CFG_DIAG_OFF_BIT] && !flags_next.supply_break &&
    !flags_next.overtemp && !flags_next.ground_break |=> ost_reg == OST_NORMAL)
    else $error("diagnosis forced output while disabled");
  latch_hold_a: assert property (@(posedge aclk) disable iff (!aresetn) // see RQ11
    ce && customer_configuration_word_reg[CFG_LATCH_BIT] |=> (flags_reg & $past(flags_reg)) == $past(flags_reg))
    else $error("latched flag dropped");
  undervolt_on_a: assert property (@(posedge aclk) disable iff (!aresetn) // see RQ1
    ce && faults_i.undervolt |=> flags_reg.undervolt)
    else $error("undervoltage not flagged");
  check_gate_a: assert property (@(posedge aclk) disable iff (!aresetn) // see RQ2
    ce && !check_en_reg[CHK_ADD_BIT] && !customer_configuration_word_reg[CFG_LATCH_BIT] |=> !flags_reg.adder_ovf)
    else $error("disabled adder check raised a flag");
  duty_order_a: assert property (@(posedge aclk) disable iff (!aresetn) // see RQ12, RQ8
    pwm_fault && flags_next.adder_ovf && !flags_next.mem_fail && !flags_next.fsm_fail &&
    !flags_next.rom_fail |-> duty_sel == DUTY_ADDER)
    else $error("wrong fault duty code");
endmodule
`default_nettype wire

// >>> verif/sfi_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// System controller: measures the pulse-width output
// ---------------------------------------------------------------
module sfi_ctrl_model (
  // Clock
  input wire logic aclk,
  // Pin
  input wire logic pwm_i,
  // Measurements
  output logic [15:0] period_cnt,
  output logic [15:0] high_cnt
);
  logic prev_reg;
  logic [15:0] cnt_reg;

  initial begin
    prev_reg = 1'b0;
    cnt_reg = 16'h0000;
    period_cnt = 16'h0000;
    high_cnt = 16'h0000;
  end

  // Period is rise to rise, high time rise to fall; a steady pin updates nothing
  always @(posedge aclk) begin
    prev_reg <= pwm_i;
    if (pwm_i === 1'b1 && prev_reg === 1'b0) begin
      period_cnt <= cnt_reg;
      cnt_reg <= 16'h0001;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
      if (pwm_i === 1'b0 && prev_reg === 1'b1) begin
        high_cnt <= cnt_reg;
      end
    end
  end
endmodule
`default_nettype wire

// >>> verif/sensor_fault_indicator_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module sensor_fault_indicator_tb_top import sfi_pkg::*;;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, pwm_o, out_oe_n, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] out_level, period_cnt, high_cnt;
  sfi_fault_t faults_i = '0;
  logic [15:0] sig = 16'h1234;
  logic [6:0] duty = 7'h32;
  int error_cnt = 0, tests_run = 0, cyc = 0;
  localparam logic [8:0] PF [0:4] = '{9'h008, 9'h004, 9'h013, 9'h051, 9'h050};
  localparam int PD [0:4] = '{95, 95, 95, 85, 75};

  always #12.5 aclk = ~aclk;

  sfi_top dut_u (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .faults_i(faults_i), .signal_level_i(sig), .duty_pct_i(duty),
    .out_level(out_level), .pwm_o(pwm_o), .out_oe_n(out_oe_n), .irq(irq));

  sfi_ctrl_model ctrl_u (.aclk(aclk), .pwm_i(pwm_o), .period_cnt(period_cnt), .high_cnt(high_cnt));

  // ---------------------------------------------------------------
  // Bench tasks
  // ---------------------------------------------------------------
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // A hang is cut short here; the run needs about 5200 cycles
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      print_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk({30'h0, bresp}, (a <= ADDR_OUT_STATE && a[1:0] == 2'h0) ? 32'h0 : 32'h2);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, exp);
    chk({30'h0, r}, 32'h0);
  endtask

  // Fault change, then one edge for the output to follow
  task automatic fault(input logic [8:0] f);
    @(posedge aclk);
    faults_i <= sfi_fault_t'(f);
    @(posedge aclk);
    #1;
  endtask

  task automatic lvl(input logic [8:0] f, input logic [15:0] exp, input logic [1:0] st);
    fault(f);
    chk({16'h0, out_level}, {16'h0, exp});
    rchk(ADDR_OUT_STATE, {30'h0, st});
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    int n;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(ADDR_CFG, 32'h0);
    rchk(ADDR_PERIOD, 32'h9c40);
    rchk(ADDR_CHECK_EN, 32'h0);
    rchk(ADDR_IRQ_MASK, 32'h0);
    rd(8'h20, d, r);
    chk({30'h0, r}, 32'h2);
    chk(d, 32'h0);
    wr(8'h20, 32'h1);
    // Analogue variant: band selection and forcing
    lvl(9'h000, 16'h1234, 2'h0);
    lvl(9'h040, LVL_HIGH_BAND, 2'h1);
    wr(ADDR_CFG, 32'h0080);
    lvl(9'h040, LVL_HIGH_BAND, 2'h1);
    wr(ADDR_CFG, 32'h0081);
    lvl(9'h040, LVL_LOW_BAND, 2'h1);
    wr(ADDR_CFG, 32'h0001);
    lvl(9'h080, LVL_HIGH_BAND, 2'h1);
    wr(ADDR_CFG, 32'h0002);
    lvl(9'h040, 16'h1234, 2'h0);
    wr(ADDR_CFG, 32'h0000);
    lvl(9'h100, LVL_GROUND, 2'h2);
    lvl(9'h008, 16'h1234, 2'h0);
    wr(ADDR_CHECK_EN, 32'hf);
    lvl(9'h008, LVL_HIGH_BAND, 2'h1);
    wr(ADDR_CFG, 32'h0008);
    lvl(9'h010, 16'h1234, 2'h0);
    wr(ADDR_CFG, 32'h0000);
    lvl(9'h010, LVL_HIGH_BAND, 2'h1);
    // Clock enable low freezes the output
    @(posedge aclk);
    ce <= 1'b0;
    fault(9'h100);
    chk({16'h0, out_level}, {16'h0, LVL_HIGH_BAND});
    @(posedge aclk);
    ce <= 1'b1;
    @(posedge aclk);
    #1;
    chk({16'h0, out_level}, {16'h0, LVL_GROUND});
    lvl(9'h000, 16'h1234, 2'h0);
    rchk(ADDR_FLAGS, 32'h0);
    // Interrupt: raise, clear by read, then masked
    rd(ADDR_IRQ_STAT, d, r);
    wr(ADDR_IRQ_MASK, 32'h040);
    fault(9'h040);
    @(posedge aclk);
    #1;
    chk({31'h0, irq}, 32'h1);
    rchk(ADDR_IRQ_STAT, 32'h040);
    repeat (2) @(posedge aclk);
    #1;
    chk({31'h0, irq}, 32'h0);
    wr(ADDR_IRQ_MASK, 32'h000);
    fault(9'h000);
    fault(9'h040);
    repeat (2) @(posedge aclk);
    #1;
    chk({31'h0, irq}, 32'h0);
    rchk(ADDR_IRQ_STAT, 32'h040);
    // Pulse-width variant
    fault(9'h000);
    wr(ADDR_PERIOD, 32'h64);
    wr(ADDR_CTRL, 32'h1);
    repeat (400) @(posedge aclk);
    chk({16'h0, period_cnt}, 32'd100);
    chk({16'h0, high_cnt}, 32'd50);
    for (int i = 0; i < 5; i++) begin
      fault(PF[i]);
      repeat (600) @(posedge aclk);
      chk({16'h0, period_cnt}, 32'd200);
      chk({16'h0, high_cnt}, PD[i] * 2);
    end
    fault(9'h040);
    repeat (600) @(posedge aclk);
    n = 0;
    repeat (400) begin
      @(posedge aclk);
      #1;
      if (pwm_o === 1'b1) n++;
    end
    chk(n, 400);
    fault(9'h000);
    repeat (600) @(posedge aclk);
    chk({16'h0, period_cnt}, 32'd100);
    fault(9'h020);
    chk({31'h0, out_oe_n}, 32'h1);
    rchk(ADDR_OUT_STATE, 32'h3);
    fault(9'h000);
    chk({31'h0, out_oe_n}, 32'h0);
    // Latched flags outlive the fault
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_CFG, 32'h0004);
    fault(9'h040);
    fault(9'h000);
    rchk(ADDR_FLAGS, 32'h040);
    print_verdict();
  end
endmodule
`default_nettype wire
